// *** rtl/atsc_pkg.sv ***
// Constants, types and helpers for the acquisition trigger and strobe controller.
// Assumes one 200 MHz core clock; all programmable delays count 500 ns ticks.
package atsc_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned TICK_NS = 500;
	localparam int unsigned TICK_CYC = TICK_NS * CLK_MHZ / 1000;
	localparam int unsigned BASE_DELAY_NS = 8200;
	localparam int unsigned BASE_CYC = (BASE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PIX_RESET_NS = 9000;
	localparam int unsigned PIX_RESET_CYC = (PIX_RESET_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONT_MIN_NS = 2000;
	localparam longint unsigned CONT_MAX_S = 60;
	localparam int unsigned CONT_PER_MIN = CONT_MIN_NS / TICK_NS;
	localparam int unsigned CONT_PER_MAX = int'(CONT_MAX_S * 64'd1000000000 / TICK_NS);
	localparam int unsigned INTEG_W = 24;
	localparam int unsigned DLY_W = 16;
	localparam int unsigned PER_W = 27;
	localparam int unsigned CNT_W = 34;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_INTEG = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TRIG_DLY = 8'h08;
	localparam logic [ADDR_W-1:0] REG_RISE = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_FALL = 8'h10;
	localparam logic [ADDR_W-1:0] REG_CONT_PER = 8'h14;
	localparam logic [ADDR_W-1:0] REG_CONT_OFF = 8'h18;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h20;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_LAMP_BIT = 2;
	localparam int unsigned CTRL_CONT_BIT = 3;
	localparam int unsigned CTRL_SYNC_BIT = 4;
	localparam int unsigned CMD_REQ_BIT = 0;
	localparam int unsigned CMD_DRAIN_BIT = 1;
	localparam logic [INTEG_W-1:0] INTEG_RST = 24'h0000C8;
	localparam logic [PER_W-1:0] CONT_PER_RST = 27'h00003E8;

	typedef enum logic [1:0] {
		ATSC_MODE_FREE = 2'b00,
		ATSC_MODE_SYNC = 2'b01,
		ATSC_MODE_LEVEL = 2'b10,
		ATSC_MODE_EDGE = 2'b11
	} atsc_mode_t;

	typedef enum logic [1:0] {
		ATSC_ST_WAIT = 2'b00,
		ATSC_ST_DELAY = 2'b01,
		ATSC_ST_INTEG = 2'b10,
		ATSC_ST_IDLE = 2'b11
	} atsc_state_t;

	typedef struct packed {
		atsc_mode_t mode;
		logic lamp_en;
		logic cont_en;
		logic cont_sync;
		logic [INTEG_W-1:0] integ;
		logic [DLY_W-1:0] trig_dly;
		logic [DLY_W-1:0] rise;
		logic [DLY_W-1:0] fall;
		logic [DLY_W-1:0] cont_off;
		logic [PER_W-1:0] cont_per;
	} atsc_cfg_t;

	localparam atsc_cfg_t CFG_RST = '{mode: ATSC_MODE_FREE, lamp_en: 1'b0, cont_en: 1'b0,
		cont_sync: 1'b0, integ: INTEG_RST, trig_dly: 16'h0000, rise: 16'h0000,
		fall: 16'h0000, cont_off: 16'h0000, cont_per: CONT_PER_RST};

	// Ticks of 500 ns to core cycles
	function automatic logic [CNT_W-1:0] atsc_to_cyc(input logic [PER_W-1:0] ticks);
		return CNT_W'(ticks) * CNT_W'(TICK_CYC);
	endfunction
endpackage

// *** rtl/atsc_top.sv ***
// Acquisition sequencer with single and continuous lamp strobes.
// Assumes a same-clock register master and an asynchronous external trigger pin.
`timescale 1ns/1ps
`default_nettype none
module atsc_top
	import atsc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ext_trigger,
	output logic readout_gate_pulse,
	output logic readout_store,
	output logic readout_discard,
	output logic integrating,
	output logic single_strobe,
	output logic cont_strobe
);
	atsc_cfg_t cfg_ff, nxt_cfg;
	atsc_state_t state_ff, nxt_state;
	logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
	logic req_ff, buf_full_ff, started_ff;
	logic gate_ff, store_ff, discard_ff, integ_ff, single_ff, cont_ff;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [CNT_W-1:0] per_cnt_ff, soi_cnt_ff, gate_cnt_ff, cs_cnt_ff;
	logic [CNT_W-1:0] nxt_per_cnt, nxt_soi_cnt, nxt_cs_cnt;
	logic cs_arm_ff, nxt_cs_arm, nxt_cs_lvl;
	logic integration_start_event, store, discard, consume, idle_go, keep, end_now;

	// Register decode
	wire cmd_hit = reg_wr && (reg_addr == REG_CMD);
	wire cmd_req = cmd_hit && reg_wdata[CMD_REQ_BIT];
	wire cmd_drain = cmd_hit && reg_wdata[CMD_DRAIN_BIT];
	// Out-of-range periods are clamped so the strobe never stalls
	wire [PER_W-1:0] per_wr = (reg_wdata < 32'(CONT_PER_MIN)) ? PER_W'(CONT_PER_MIN) :
		(reg_wdata > 32'(CONT_PER_MAX)) ? PER_W'(CONT_PER_MAX) : reg_wdata[PER_W-1:0];

	// Trigger edge and level, taken only from the synchronised stages
	wire trig_lvl = trig_s2_ff;
	wire trig_rise = trig_s2_ff && !trig_s3_ff;

	// Cycle counts derived from tick settings
	wire [CNT_W-1:0] integ_cyc = atsc_to_cyc(PER_W'(cfg_ff.integ));
	wire [CNT_W-1:0] dly_cyc = atsc_to_cyc(PER_W'(cfg_ff.trig_dly)) + CNT_W'(BASE_CYC);
	wire [CNT_W-1:0] rise_cyc = atsc_to_cyc(PER_W'(cfg_ff.rise));
	wire [CNT_W-1:0] fall_cyc = atsc_to_cyc(PER_W'(cfg_ff.fall));
	wire [CNT_W-1:0] off_cyc = atsc_to_cyc(PER_W'(cfg_ff.cont_off));
	wire [CNT_W-1:0] half_cyc = atsc_to_cyc(cfg_ff.cont_per) >> 1;
	wire [CNT_W-1:0] per_next = per_cnt_ff + CNT_W'(1);
	wire integ_done = per_next >= integ_cyc;
	wire dly_done = per_next >= dly_cyc;
	wire ext_mode = cfg_ff.mode != ATSC_MODE_FREE;
	wire cs_on = cfg_ff.lamp_en && cfg_ff.cont_en;
	wire cs_half = (nxt_cs_cnt == '0) && (cs_cnt_ff != '0);

	// Strobe window tracks the counter value that will hold after this edge
	wire nxt_single = cfg_ff.lamp_en && (started_ff || integration_start_event) &&
		(nxt_soi_cnt >= rise_cyc) && (nxt_soi_cnt < fall_cyc);

	always_comb begin
		nxt_cfg = cfg_ff;
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: begin
					nxt_cfg.mode = atsc_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
					nxt_cfg.lamp_en = reg_wdata[CTRL_LAMP_BIT];
					nxt_cfg.cont_en = reg_wdata[CTRL_CONT_BIT];
					nxt_cfg.cont_sync = reg_wdata[CTRL_SYNC_BIT];
				end
				REG_INTEG: nxt_cfg.integ = reg_wdata[INTEG_W-1:0];
				REG_TRIG_DLY: nxt_cfg.trig_dly = reg_wdata[DLY_W-1:0];
				REG_RISE: nxt_cfg.rise = reg_wdata[DLY_W-1:0];
				REG_FALL: nxt_cfg.fall = reg_wdata[DLY_W-1:0];
				REG_CONT_PER: nxt_cfg.cont_per = per_wr;
				REG_CONT_OFF: nxt_cfg.cont_off = reg_wdata[DLY_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		case (reg_addr)
			REG_CTRL: nxt_rdata = {27'h0000000, cfg_ff.cont_sync, cfg_ff.cont_en,
				cfg_ff.lamp_en, cfg_ff.mode};
			REG_INTEG: nxt_rdata = {8'h00, cfg_ff.integ};
			REG_TRIG_DLY: nxt_rdata = {16'h0000, cfg_ff.trig_dly};
			REG_RISE: nxt_rdata = {16'h0000, cfg_ff.rise};
			REG_FALL: nxt_rdata = {16'h0000, cfg_ff.fall};
			REG_CONT_PER: nxt_rdata = {5'h00, cfg_ff.cont_per};
			REG_CONT_OFF: nxt_rdata = {16'h0000, cfg_ff.cont_off};
			REG_STATUS: nxt_rdata = {24'h000000, cont_ff, single_ff, gate_ff, trig_lvl,
				state_ff, req_ff, buf_full_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
		if (!reg_rd) begin
			nxt_rdata = 32'h00000000;
		end
	end

	// Acquisition sequencer
	always_comb begin
		nxt_state = state_ff;
		integration_start_event = 1'b0;
		store = 1'b0;
		discard = 1'b0;
		consume = 1'b0;
		idle_go = 1'b0;
		// Edge mode keeps data only for a pending request
		keep = !buf_full_ff && ((cfg_ff.mode != ATSC_MODE_EDGE) || req_ff);
		end_now = (cfg_ff.mode == ATSC_MODE_SYNC) ? trig_rise : integ_done;
		case (state_ff)
			ATSC_ST_WAIT: begin
				if (!ext_mode) begin
					if (req_ff && !buf_full_ff) begin
						integration_start_event = 1'b1;
						consume = 1'b1;
						nxt_state = ATSC_ST_INTEG;
					end
				end else if (trig_rise && !buf_full_ff) begin
					nxt_state = ATSC_ST_DELAY;
				end
			end
			ATSC_ST_DELAY: begin
				if (dly_done) begin
					integration_start_event = 1'b1;
					nxt_state = ATSC_ST_INTEG;
				end
			end
			ATSC_ST_INTEG: begin
				if (end_now) begin
					store = keep;
					discard = !keep;
					consume = keep && (cfg_ff.mode == ATSC_MODE_EDGE);
					case (cfg_ff.mode)
						ATSC_MODE_FREE: begin
							if (keep) begin
								integration_start_event = 1'b1;
							end else begin
								nxt_state = ATSC_ST_IDLE;
							end
						end
						ATSC_MODE_SYNC: nxt_state = ATSC_ST_DELAY;
						ATSC_MODE_LEVEL: begin
							if (trig_lvl) begin
								integration_start_event = 1'b1;
							end else begin
								nxt_state = ATSC_ST_WAIT;
							end
						end
						default: nxt_state = ATSC_ST_WAIT;
					endcase
				end
			end
			ATSC_ST_IDLE: begin
				if (integ_done) begin
					if (!buf_full_ff && req_ff) begin
						integration_start_event = 1'b1;
						consume = 1'b1;
						nxt_state = ATSC_ST_INTEG;
					end else begin
						idle_go = 1'b1;
					end
				end
			end
			default: nxt_state = ATSC_ST_WAIT;
		endcase
	end

	wire restart = integration_start_event || idle_go || (nxt_state != state_ff);
	assign nxt_per_cnt = restart ? '0 : per_next;
	assign nxt_soi_cnt = integration_start_event ? '0 : ((&soi_cnt_ff) ? soi_cnt_ff : soi_cnt_ff + CNT_W'(1));

	// Continuous strobe: free form runs on its own, sync form restarts at each start
	always_comb begin
		nxt_cs_cnt = cs_cnt_ff + CNT_W'(1);
		nxt_cs_lvl = cont_ff;
		nxt_cs_arm = cs_arm_ff;
		if (!cs_on) begin
			nxt_cs_cnt = '0;
			nxt_cs_lvl = 1'b0;
			nxt_cs_arm = !cfg_ff.cont_sync;
		end else if (cfg_ff.cont_sync && integration_start_event) begin
			nxt_cs_cnt = '0;
			nxt_cs_lvl = 1'b0;
			nxt_cs_arm = 1'b0;
		end else if (!cs_arm_ff && cfg_ff.cont_sync) begin
			if (nxt_cs_cnt >= off_cyc) begin
				nxt_cs_cnt = '0;
				nxt_cs_lvl = 1'b1;
				nxt_cs_arm = 1'b1;
			end
		end else if (nxt_cs_cnt >= half_cyc) begin
			nxt_cs_cnt = '0;
			nxt_cs_lvl = !cont_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_s3_ff <= 1'b0;
		end else if (clk_en) begin
			trig_s1_ff <= ext_trigger;
			trig_s2_ff <= trig_s1_ff;
			trig_s3_ff <= trig_s2_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= CFG_RST;
			rdata_ff <= 32'h00000000;
			state_ff <= ATSC_ST_WAIT;
			per_cnt_ff <= '0;
			soi_cnt_ff <= '0;
		end else if (clk_en) begin
			cfg_ff <= nxt_cfg;
			rdata_ff <= nxt_rdata;
			state_ff <= nxt_state;
			per_cnt_ff <= nxt_per_cnt;
			soi_cnt_ff <= nxt_soi_cnt;
		end
	end

	// Set wins over clear for both the request and the buffer flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ff <= 1'b0;
			buf_full_ff <= 1'b0;
			started_ff <= 1'b0;
			store_ff <= 1'b0;
			discard_ff <= 1'b0;
			integ_ff <= 1'b0;
		end else if (clk_en) begin
			req_ff <= cmd_req || (req_ff && !consume);
			buf_full_ff <= store || (buf_full_ff && !cmd_drain);
			started_ff <= started_ff || integration_start_event;
			store_ff <= store;
			discard_ff <= discard;
			integ_ff <= nxt_state == ATSC_ST_INTEG;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gate_ff <= 1'b0;
			gate_cnt_ff <= '0;
		end else if (clk_en) begin
			if (integration_start_event) begin
				gate_ff <= 1'b1;
				gate_cnt_ff <= '0;
			end else if (gate_ff) begin
				gate_ff <= gate_cnt_ff != CNT_W'(PIX_RESET_CYC - 1);
				gate_cnt_ff <= gate_cnt_ff + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			single_ff <= 1'b0;
			cont_ff <= 1'b0;
			cs_cnt_ff <= '0;
			cs_arm_ff <= 1'b1;
		end else if (clk_en) begin
			single_ff <= nxt_single;
			cont_ff <= nxt_cs_lvl && cs_on;
			cs_cnt_ff <= nxt_cs_cnt;
			cs_arm_ff <= nxt_cs_arm;
		end
	end

	assign reg_rdata = rdata_ff;
	assign readout_gate_pulse = gate_ff;
	assign readout_store = store_ff;
	assign readout_discard = discard_ff;
	assign integrating = integ_ff;
	assign single_strobe = single_ff;
	assign cont_strobe = cont_ff;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	chk_lamp_gate: assert property (
		($past(clk_en) && !$past(cfg_ff.lamp_en)) |-> (!single_ff && !cont_ff))
		else $error("strobe active while lamp disabled");
	chk_gate_soi: assert property (
		$rose(gate_ff) |-> (soi_cnt_ff == '0) && started_ff)
		else $error("gate rise not at integration start");
	chk_gate_width: assert property (
		$fell(gate_ff) |-> ($past(gate_cnt_ff) == CNT_W'(PIX_RESET_CYC - 1)))
		else $error("pixel reset window length wrong");
	chk_strobe_rise: assert property (
		$rose(single_ff) |-> (soi_cnt_ff >= rise_cyc) && (soi_cnt_ff < fall_cyc))
		else $error("single strobe outside its window");
	chk_strobe_fall: assert property (
		($fell(single_ff) && $past(clk_en) && $stable(cfg_ff) && cfg_ff.lamp_en)
		|-> (soi_cnt_ff == fall_cyc) || (soi_cnt_ff == '0))
		else $error("single strobe fell at wrong time");
	chk_trig_delay: assert property (
		(state_ff == ATSC_ST_DELAY && nxt_state == ATSC_ST_INTEG) |-> (per_next == dly_cyc))
		else $error("start delay length wrong");
	chk_idle_discard: assert property (
		(state_ff == ATSC_ST_INTEG && nxt_state == ATSC_ST_IDLE) |-> discard && !store)
		else $error("idle period without discard");
	chk_wait_empty: assert property (
		(state_ff == ATSC_ST_WAIT && nxt_state != ATSC_ST_WAIT) |-> !buf_full_ff)
		else $error("acquisition began with buffer full");
	chk_store_fills: assert property (
		(store && clk_en) |=> (buf_full_ff && store_ff))
		else $error("stored spectrum not marked buffered");
	chk_edge_once: assert property (
		(state_ff == ATSC_ST_INTEG && end_now && cfg_ff.mode == ATSC_MODE_EDGE)
		|-> (nxt_state == ATSC_ST_WAIT) && !integration_start_event)
		else $error("edge mode repeated integration");
	chk_level_stop: assert property (
		(state_ff == ATSC_ST_INTEG && end_now && cfg_ff.mode == ATSC_MODE_LEVEL)
		|-> (integration_start_event == trig_lvl))
		else $error("level mode repeat wrong");
	chk_cont_half: assert property (
		($changed(cont_ff) && $past(clk_en) && $past(cs_arm_ff) && cs_arm_ff &&
		$stable(cfg_ff) && cs_on && $past(cs_on)) |-> ($past(cs_cnt_ff) + CNT_W'(1) == half_cyc))
		else $error("continuous strobe half period wrong");
	chk_sync_restart: assert property (
		(clk_en && cs_on && cfg_ff.cont_sync && integration_start_event) |=> (!cont_ff && cs_cnt_ff == '0))
		else $error("synchronous strobe not restarted at start");
	chk_idle_restart: assert property (
		(state_ff == ATSC_ST_IDLE && integration_start_event) |-> (req_ff && !buf_full_ff && integ_done))
		else $error("restart after idle without request or empty buffer");
	chk_sync_edge_end: assert property (
		(state_ff == ATSC_ST_INTEG && cfg_ff.mode == ATSC_MODE_SYNC && trig_rise)
		|-> (nxt_state == ATSC_ST_DELAY))
		else $error("sync edge did not end integration");
	chk_free_b2b: assert property (
		(state_ff == ATSC_ST_INTEG && cfg_ff.mode == ATSC_MODE_FREE && end_now && keep)
		|-> (integration_start_event && store))
		else $error("free-run did not store and restart");
	// Level mode must show a repeat at least once in the bench
	cov_level_repeat: cover property (cfg_ff.mode == ATSC_MODE_LEVEL && state_ff == ATSC_ST_INTEG && integration_start_event);

	cov_back_to_back: cover property (state_ff == ATSC_ST_INTEG && integration_start_event && store);
	cov_idle_cycle: cover property (state_ff == ATSC_ST_IDLE && integration_start_event);
	cov_edge_store: cover property (cfg_ff.mode == ATSC_MODE_EDGE && store);
	cov_sync_strobe: cover property (cfg_ff.cont_sync && $rose(cont_ff));
endmodule // atsc_top
`default_nettype wire

// *** sim/atsc_top_bench.sv ***
// Self-checking bench for the acquisition trigger and strobe controller.
// Assumes the register map and cycle figures of the controller package.
`timescale 1ns/1ps
`default_nettype none
module atsc_top_bench;
	import atsc_pkg::*;
	logic core_clk, rst_n, clk_en, reg_wr, reg_rd, fire;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [15:0] width;
	logic ext_trigger, gate, store, discard, integrating, single, cont;
	wire [4:0] mon = {discard, store, cont, single, gate};
	int bad_count = 0;
	int total_checks = 0;
	int n;

	atsc_top u_atsc_top (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_trigger(ext_trigger), .readout_gate_pulse(gate),
		.readout_store(store), .readout_discard(discard), .integrating(integrating),
		.single_strobe(single), .cont_strobe(cont));
	atsc_trig_model u_atsc_trig_model (.core_clk(core_clk), .fire(fire), .width(width),
		.ext_trigger(ext_trigger));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Counts clock edges until a monitored output reaches a level, up to lim
	task automatic wait_sig(input int idx, input logic v, input int lim, output int cnt);
		cnt = 0;
		while (mon[idx] !== v && cnt < lim) begin
			@(posedge core_clk);
			#1;
			cnt++;
		end
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask

	task automatic t_defaults();
		rd(REG_CTRL, rv);
		check(rv, 32'h0000_0000);
		rd(REG_INTEG, rv);
		check(rv, 32'h0000_00C8);
		rd(REG_CONT_PER, rv);
		check(rv, 32'h0000_03E8);
		rd(8'h3C, rv);
		check(rv, 32'h0000_0000);
		for (int m = 0; m < 4; m++) begin
			wr(REG_CTRL, 32'(m));
			rd(REG_CTRL, rv);
			check(rv, 32'(m));
		end
		wr(REG_CTRL, 32'h0000_0000);
	endtask

	task automatic t_free_run();
		wr(REG_INTEG, 32'h0000_0004);
		wr(REG_RISE, 32'h0000_0001);
		wr(REG_FALL, 32'h0000_0003);
		wr(REG_CTRL, 32'h0000_0004);
		wr(REG_CMD, 32'h0000_0001);
		wait_sig(0, 1'b1, 20, n);
		check({31'h0, integrating}, 32'h1);
		wait_sig(1, 1'b1, 400, n);
		check(32'(n), 32'd100);
		wait_sig(1, 1'b0, 400, n);
		check(32'(n), 32'd200);
		wait_sig(3, 1'b1, 400, n);
		check(32'(n), 32'd100);
		@(posedge core_clk);
		#1;
		check({31'h0, gate}, 32'h1);
		// Buffer still full at the next end, so that spectrum must be dropped
		wait_sig(4, 1'b1, 600, n);
		check(32'(n), 32'd399);
		// Gate of the last start is still high here; let it end first
		wait_sig(0, 1'b0, 2000, n);
		check(32'(n), 32'd1400);
		wait_sig(0, 1'b1, 1000, n);
		check({31'h0, gate}, 32'h0);
		wr(REG_CMD, 32'h0000_0003);
		wait_sig(0, 1'b1, 1000, n);
		check({31'h0, gate}, 32'h1);
	endtask

	task automatic t_edge();
		do_reset();
		wr(REG_INTEG, 32'h0000_0001);
		wr(REG_TRIG_DLY, 32'h0000_0001);
		wr(REG_FALL, 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0003);
		@(posedge core_clk);
		fire <= 1'b1;
		width <= 16'd3000;
		@(posedge core_clk);
		fire <= 1'b0;
		wait (ext_trigger === 1'b1);
		wait_sig(0, 1'b1, 2000, n);
		check({31'h0, (n >= 1740 && n <= 1750)}, 32'h1);
		check({31'h0, single}, 32'h0);
		wait_sig(4, 1'b1, 200, n);
		check(32'(n), 32'd100);
		// Trigger stays high long after: still only one integration
		wait_sig(0, 1'b0, 2000, n);
		check(32'(n), 32'd1700);
		wait_sig(0, 1'b1, 2500, n);
		check({31'h0, gate}, 32'h0);
	endtask

	task automatic t_level();
		do_reset();
		wr(REG_INTEG, 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0002);
		@(posedge core_clk);
		fire <= 1'b1;
		width <= 16'd2000;
		@(posedge core_clk);
		fire <= 1'b0;
		wait_sig(3, 1'b1, 2500, n);
		check({31'h0, integrating}, 32'h1);
		// Buffer now full: the repeat runs but its data is dropped
		wait_sig(4, 1'b1, 200, n);
		check(32'(n), 32'd100);
	endtask

	task automatic t_cont();
		do_reset();
		wr(REG_CONT_PER, 32'h0000_0001);
		rd(REG_CONT_PER, rv);
		check(rv, 32'h0000_0004);
		wr(REG_CTRL, 32'h0000_0008);
		repeat (500) @(posedge core_clk);
		check({31'h0, cont}, 32'h0);
		wr(REG_CTRL, 32'h0000_000C);
		wait_sig(2, 1'b1, 500, n);
		wait_sig(2, 1'b0, 500, n);
		check(32'(n), 32'd200);
		wait_sig(2, 1'b1, 500, n);
		check(32'(n), 32'd200);
		clk_en <= 1'b0;
		rv = {31'h0, cont};
		repeat (300) @(posedge core_clk);
		#1;
		check({31'h0, cont}, rv);
		clk_en <= 1'b1;
		wr(REG_CONT_OFF, 32'h0000_0001);
		// Period of 4 ticks stays far below half the 200-tick integration minus offset
		wr(REG_CTRL, 32'h0000_001C);
		wr(REG_CMD, 32'h0000_0001);
		wait_sig(0, 1'b1, 20, n);
		wait_sig(2, 1'b1, 300, n);
		check(32'(n), 32'd100);
		wait_sig(2, 1'b0, 300, n);
		check(32'(n), 32'd200);
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		fire = 1'b0;
		width = 16'd0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_defaults();
		t_free_run();
		t_edge();
		t_level();
		t_cont();
		wrap_up();
	end

	// Scenarios need some 13400 cycles; allow ample margin
	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end
endmodule // atsc_top_bench
`default_nettype wire

// *** sim/atsc_trig_model.sv ***
// Behavioural external trigger source facing the acquisition controller.
// Assumes the bench asks for each pulse with a one-cycle fire strobe.
`timescale 1ns/1ps
`default_nettype none
module atsc_trig_model (
	input wire logic core_clk,
	input wire logic fire,
	input wire logic [15:0] width,
	output var logic ext_trigger
);
	initial ext_trigger = 1'b0;
	// Pin moves off the clock edge on purpose: it is asynchronous to the core
	always @(posedge core_clk) begin
		if (fire) begin
			#2.3;
			ext_trigger = 1'b1;
			repeat (width) @(posedge core_clk);
			#1.7;
			ext_trigger = 1'b0;
		end
	end
endmodule // atsc_trig_model
`default_nettype wire
